// ### src/bmcr_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants and types for the board control register bank
// Assumes: One 10 MHz system clock, 8-bit host register port
// Notes:   Register indices are small word indices on the host register port
//------------------------------------------------------------------------------
package bmcr_pkg;

  //----------------------------------------------------------------------------
  // Register port geometry and indices
  //----------------------------------------------------------------------------
  localparam int         ADDR_W    = 3;
  localparam int         DATA_W    = 8;
  localparam logic [2:0] IDX_XCVR  = 3'h0;  // com_transceiver_mode
  localparam logic [2:0] IDX_AUX   = 3'h1;  // aux_gpio_irq_config
  localparam logic [2:0] IDX_FAN   = 3'h2;  // fan_control
  localparam logic [2:0] IDX_TACHL = 3'h3;  // fan_tach_count_low
  localparam logic [2:0] IDX_TACHH = 3'h4;  // fan_tach_count_high
  localparam logic [2:0] IDX_TICR  = 3'h5;  // thermal_irq_control
  localparam logic [2:0] IDX_TSTAT = 3'h6;  // thermal_irq_status

  //----------------------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------------------
  localparam int PORT_A_BIT   = 0;
  localparam int PORT_B_BIT   = 1;
  localparam int IRQ_EN_BIT   = 7;
  localparam int IRQ_SEL_LSB  = 4;
  localparam int FAN_OFF_BIT  = 0;
  localparam int BATT_IN_BIT  = 7;
  localparam int SRC_W        = 4;

  //----------------------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------------------
  localparam logic [1:0] XCVR_RST   = 2'h0;
  localparam logic       FAN_RST    = 1'b0;
  localparam logic [3:0] MASK_RST   = 4'h0;
  localparam logic [3:0] PEND_RST   = 4'h0;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [15:0] IRQ_RST   = 16'h0000;

  //----------------------------------------------------------------------------
  // Tachometer timing
  //----------------------------------------------------------------------------
  localparam longint TACH_WINDOW_NS  = 1000000000;  // One second window
  localparam longint CLK_PERIOD_NS   = 100;
  localparam int     TACH_WINDOW_CYC = int'(TACH_WINDOW_NS / CLK_PERIOD_NS);
  localparam int     TACH_W          = 10;
  localparam logic [9:0] TACH_MAX    = 10'h3ff;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic [2:0] line_sel;
  } bmcr_irq_cfg_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bmcr_host_req_t;

  // Bit order matches mask and pending bits 3..0
  typedef struct packed {
    logic battery_low;
    logic dimm_event;
    logic sensor_thermal;
    logic sensor_alert;
  } bmcr_src_t;

  // Line selector code to interrupt number on the serialized line
  function automatic logic [3:0] bmcr_irq_number(input logic [2:0] sel);
    logic [3:0] num;
    num = 4'h3;
    unique case (sel)
      3'h0: num = 4'h3;
      3'h1: num = 4'h4;
      3'h2: num = 4'h5;
      3'h3: num = 4'ha;
      3'h4: num = 4'h6;
      3'h5: num = 4'h7;
      3'h6: num = 4'h9;
      3'h7: num = 4'hb;
    endcase
    return num;
  endfunction : bmcr_irq_number

endpackage : bmcr_pkg

// ### src/bmcr_fan_tach.sv
//------------------------------------------------------------------------------
// Purpose: Fan tachometer pulse counter over fixed windows
// Assumes: pulse_in already synchronised to clock_in
// Notes:   Result is published once per window and saturates
//------------------------------------------------------------------------------
module bmcr_fan_tach #(
  parameter int WINDOW_CYCLES = bmcr_pkg::TACH_WINDOW_CYC,
  parameter int COUNT_W       = bmcr_pkg::TACH_W
) (
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  input  wire logic               pulse_in,
  output logic [COUNT_W-1:0]      count_out
);
  import bmcr_pkg::*;

  localparam int TMR_W = $clog2(WINDOW_CYCLES);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WINDOW_CYCLES - 1);
  localparam logic [COUNT_W-1:0] CNT_MAX = {COUNT_W{1'b1}};

  // Refuse windows too short to count in
  if (WINDOW_CYCLES < 2 || COUNT_W < 1) begin : g_bad_param
    $error("bmcr_fan_tach: window or width out of range");
  end

  logic               prev_reg,  prev_next;
  logic [TMR_W-1:0]   tmr_reg,   tmr_next;
  logic [COUNT_W-1:0] acc_reg,   acc_next;
  logic [COUNT_W-1:0] count_reg, count_next;

  // Window timer, edge counter and publish
  always_comb begin
    prev_next  = pulse_in;
    tmr_next   = tmr_reg + TMR_W'(1);
    acc_next   = acc_reg;
    count_next = count_reg;
    if (pulse_in && !prev_reg && acc_reg != CNT_MAX) begin
      acc_next = acc_reg + COUNT_W'(1);
    end
    if (tmr_reg == TMR_LAST) begin
      tmr_next   = '0;
      count_next = acc_next;
      acc_next   = '0;
    end
  end

  // State registers
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      prev_reg  <= 1'b0;
      tmr_reg   <= '0;
      acc_reg   <= '0;
      count_reg <= '0;
    end else begin
      prev_reg  <= prev_next;
      tmr_reg   <= tmr_next;
      acc_reg   <= acc_next;
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;

endmodule : bmcr_fan_tach

// ### src/bmcr_regs.sv
//------------------------------------------------------------------------------
// Purpose: Board control register bank: transceiver mode, fan, tach, interrupts
// Assumes: Host register port decoded upstream into one-cycle rd/wr strobes
// Notes:   Pin inputs except aux_gpio_irq_in pass two flip-flops before use
//          Status flags keep source edges that land during a clear
//------------------------------------------------------------------------------
module bmcr_regs #(
  parameter int TACH_WINDOW_CYCLES = bmcr_pkg::TACH_WINDOW_CYC
) (
  input  wire logic                     clock_in,
  input  wire logic                     reset_in,
  input  wire bmcr_pkg::bmcr_host_req_t host_req_in,
  input  wire logic                     fan_tach_in,
  input  wire bmcr_pkg::bmcr_src_t      irq_src_in,
  input  wire logic                     sleep_in,
  input  wire logic                     aux_gpio_irq_in,
  output logic [7:0]                    rdata_out,
  output logic                          rdata_valid_out,
  output logic                          port_a_line_mode_out,
  output logic                          port_b_line_mode_out,
  output logic                          fan_on_out,
  output logic [15:0]                   irq_request_out
);
  import bmcr_pkg::*;

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  // Pin order: sleep, tach, then the four interrupt sources
  localparam int PIN_N = 6;

  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] sync1_next;
  logic [PIN_N-1:0] sync2_next;

  assign pins_raw = {sleep_in, fan_tach_in, irq_src_in};

  // Two flip-flops per pin
  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    always_comb begin
      sync1_next[i] = pins_raw[i];
      sync2_next[i] = sync1_reg[i];
    end
    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= sync1_next[i];
        sync2_reg[i] <= sync2_next[i];
      end
    end
  end

  logic [SRC_W-1:0] src_sync;
  logic             tach_sync;
  logic             sleep_sync;

  // Named views of the synchronised pins
  assign src_sync   = sync2_reg[SRC_W-1:0];
  assign tach_sync  = sync2_reg[SRC_W];
  assign sleep_sync = sync2_reg[SRC_W+1];

  //----------------------------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------------------------
  // A window under two cycles leaves no time to count in
  if (TACH_WINDOW_CYCLES < 2) begin : g_bad_window
    $error("bmcr_regs: tach window too short");
  end
  // Pin vector must hold the sources plus tach and sleep
  if (PIN_N != SRC_W + 2) begin : g_bad_pins
    $error("bmcr_regs: pin vector width mismatch");
  end
  // The tach reading must fit the two readable bytes
  if (TACH_W > 16) begin : g_bad_tach
    $error("bmcr_regs: tach count wider than sixteen bits");
  end

  //----------------------------------------------------------------------------
  // Tachometer counter
  //----------------------------------------------------------------------------
  logic [TACH_W-1:0] tach_count;

  // Counter sees only the synchronised tach pin
  bmcr_fan_tach #(
    .WINDOW_CYCLES (TACH_WINDOW_CYCLES),
    .COUNT_W       (TACH_W)
  ) u_tach (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .pulse_in  (tach_sync),
    .count_out (tach_count)
  );

  //----------------------------------------------------------------------------
  // Register state
  //----------------------------------------------------------------------------
  // Control state, pending flags and read path
  logic [1:0]       xcvr_reg,    xcvr_next;
  bmcr_irq_cfg_t    aux_cfg_reg, aux_cfg_next;
  logic             fan_off_reg, fan_off_next;
  bmcr_irq_cfg_t    tcfg_reg,    tcfg_next;
  logic [SRC_W-1:0] mask_reg,    mask_next;
  logic [SRC_W-1:0] pend_reg,    pend_next;
  logic [SRC_W-1:0] src_prev_reg, src_prev_next;
  logic [7:0]       hold_reg,    hold_next;
  logic [7:0]       rdata_reg,   rdata_next;
  logic             rvalid_reg,  rvalid_next;

  logic             wr_hit;
  logic             rd_hit;
  logic [SRC_W-1:0] src_rise;
  logic [15:0]      tach_word;

  // Strobes, source edges and the widened tach word
  assign wr_hit    = host_req_in.wr;
  assign rd_hit    = host_req_in.rd;
  assign src_rise  = src_sync & ~src_prev_reg;
  assign tach_word = {{(16 - TACH_W){1'b0}}, tach_count};

  //----------------------------------------------------------------------------
  // Control registers
  //----------------------------------------------------------------------------
  // Host writes to the control fields
  always_comb begin
    xcvr_next    = xcvr_reg;
    aux_cfg_next = aux_cfg_reg;
    fan_off_next = fan_off_reg;
    tcfg_next    = tcfg_reg;
    mask_next    = mask_reg;
    // Reserved bits are never stored, so they always read back as zero
    if (wr_hit) begin
      unique case (host_req_in.addr)
        IDX_XCVR: begin
          xcvr_next = host_req_in.wdata[PORT_B_BIT:PORT_A_BIT];
        end
        IDX_AUX: begin
          aux_cfg_next.enable   = host_req_in.wdata[IRQ_EN_BIT];
          aux_cfg_next.line_sel = host_req_in.wdata[IRQ_SEL_LSB +: 3];
        end
        IDX_FAN: begin
          fan_off_next = host_req_in.wdata[FAN_OFF_BIT];
        end
        IDX_TICR: begin
          tcfg_next.enable   = host_req_in.wdata[IRQ_EN_BIT];
          tcfg_next.line_sel = host_req_in.wdata[IRQ_SEL_LSB +: 3];
          mask_next          = host_req_in.wdata[SRC_W-1:0];
        end
        default: begin
          mask_next = mask_reg;  // Status, tach and unmapped writes
        end
      endcase
    end
  end

  // Control flip-flops, back to zero on platform reset
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      xcvr_reg    <= XCVR_RST;
      aux_cfg_reg <= '0;
      fan_off_reg <= FAN_RST;
      tcfg_reg    <= '0;
      mask_reg    <= MASK_RST;
    end else begin
      xcvr_reg    <= xcvr_next;
      aux_cfg_reg <= aux_cfg_next;
      fan_off_reg <= fan_off_next;
      tcfg_reg    <= tcfg_next;
      mask_reg    <= mask_next;
    end
  end

  //----------------------------------------------------------------------------
  // Interrupt pending flags
  //----------------------------------------------------------------------------
  // Write-one clear, then set by fresh source edges
  always_comb begin
    src_prev_next = src_sync;
    pend_next     = pend_reg;
    if (wr_hit && host_req_in.addr == IDX_TSTAT) begin
      pend_next = pend_reg & ~host_req_in.wdata[SRC_W-1:0];
    end
    // A set in the clearing cycle wins, so no edge is lost
    pend_next = pend_next | src_rise;
  end

  // Pending flag flip-flops
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pend_reg     <= PEND_RST;
      src_prev_reg <= PEND_RST;
    end else begin
      pend_reg     <= pend_next;
      src_prev_reg <= src_prev_next;
    end
  end

  //----------------------------------------------------------------------------
  // Read data and tach holding byte
  //----------------------------------------------------------------------------
  // Answer one cycle after the read strobe
  always_comb begin
    hold_next   = hold_reg;
    rdata_next  = rdata_reg;
    rvalid_next = rd_hit;
    if (rd_hit) begin
      unique case (host_req_in.addr)
        IDX_XCVR:  rdata_next = {6'h00, xcvr_reg};
        IDX_AUX:   rdata_next = {aux_cfg_reg, 4'h0};
        IDX_FAN:   rdata_next = {7'h00, fan_off_reg};
        IDX_TACHL: begin
          rdata_next = tach_word[7:0];
          hold_next  = tach_word[15:8];
        end
        IDX_TACHH: rdata_next = hold_reg;
        IDX_TICR:  rdata_next = {tcfg_reg, mask_reg};
        IDX_TSTAT: rdata_next = {src_sync[SRC_W-1], 3'h0, pend_reg};
        default:   rdata_next = BYTE_RST;
      endcase
    end
  end

  // Read path flip-flops
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      hold_reg   <= BYTE_RST;
      rdata_reg  <= BYTE_RST;
      rvalid_reg <= 1'b0;
    end else begin
      hold_reg   <= hold_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs: line modes, fan drive, interrupt requests
  //----------------------------------------------------------------------------
  logic [1:0]  mode_out_reg, mode_out_next;
  logic        fan_reg,      fan_next;
  logic [15:0] irq_reg,      irq_next;

  // One-hot request for a group that is enabled and has work pending
  function automatic logic [15:0] irq_vector(input bmcr_irq_cfg_t cfg, input logic active);
    logic [15:0] vec;
    vec = IRQ_RST;
    if (cfg.enable && active) begin
      vec[bmcr_irq_number(cfg.line_sel)] = 1'b1;
    end
    return vec;
  endfunction : irq_vector

  // Output values derived from control state
  always_comb begin
    mode_out_next = xcvr_reg;
    // Sleep overrides the register so the fan never runs asleep
    fan_next      = !fan_off_reg && !sleep_sync;
    irq_next      = irq_vector(tcfg_reg, |(pend_reg & mask_reg));
    irq_next      = irq_next | irq_vector(aux_cfg_reg, aux_gpio_irq_in);
  end

  // Output flip-flops
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_out_reg <= XCVR_RST;
      fan_reg      <= 1'b0;
      irq_reg      <= IRQ_RST;
    end else begin
      mode_out_reg <= mode_out_next;
      fan_reg      <= fan_next;
      irq_reg      <= irq_next;
    end
  end

  // Ports come straight from their flip-flops
  assign port_a_line_mode_out = mode_out_reg[PORT_A_BIT];
  assign port_b_line_mode_out = mode_out_reg[PORT_B_BIT];
  assign fan_on_out           = fan_reg;
  assign irq_request_out      = irq_reg;
  assign rdata_out            = rdata_reg;
  assign rdata_valid_out      = rvalid_reg;

endmodule : bmcr_regs

// ### tb/bmcr_host_model.sv
// Purpose: Host side of the register port, one request per task call
// Assumes: Requests are taken on the rising edge, answer one cycle later
// Notes:   Released address and data lines show the inverse of the last value
module bmcr_host_model (
  input  wire logic               clock_in,
  input  wire logic [7:0]         rdata_in,
  input  wire logic               rdata_valid_in,
  output bmcr_pkg::bmcr_host_req_t host_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import bmcr_pkg::*;

  // Idle bus at time zero
  initial host_req_out = '0;

  // Single write strobe held across its taking edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #5 host_req_out = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock_in);
    #5 host_req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr_reg

  // Read strobe, then a bounded wait for the valid pulse
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge clock_in);
    #5 host_req_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    #5 host_req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    n = 0;
    while (rdata_valid_in !== 1'b1 && n < 4) begin
      @(posedge clock_in);
      #5 n++;
    end
    d = (n < 4) ? rdata_in : 8'hxx;
  endtask : rd_reg
endmodule : bmcr_host_model

// ### tb/bmcr_regs_monitor.sv
// Purpose: Port assertions for the board control register bank
// Assumes: Bound to every bmcr_regs instance
// Notes:   Platform reset disables all checks
module bmcr_regs_monitor #(
  parameter int TACH_WINDOW_CYCLES = bmcr_pkg::TACH_WINDOW_CYC
) (
  input wire logic                     clock_in,
  input wire logic                     reset_in,
  input wire bmcr_pkg::bmcr_host_req_t host_req_in,
  input wire logic                     fan_tach_in,
  input wire bmcr_pkg::bmcr_src_t      irq_src_in,
  input wire logic                     sleep_in,
  input wire logic                     aux_gpio_irq_in,
  input wire logic [7:0]               rdata_out,
  input wire logic                     rdata_valid_out,
  input wire logic                     port_a_line_mode_out,
  input wire logic                     port_b_line_mode_out,
  input wire logic                     fan_on_out,
  input wire logic [15:0]              irq_request_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import bmcr_pkg::*;
  //----------------------------------------
  // Port checks
  //----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  read_answer_a: assert property (host_req_in.rd |=> rdata_valid_out)
    else $error("read not answered");
  stray_valid_a: assert property (rdata_valid_out |-> $past(host_req_in.rd))
    else $error("valid without read");
  port_a_a: assert property (host_req_in.wr && host_req_in.addr == IDX_XCVR
    |=> ##1 port_a_line_mode_out == $past(host_req_in.wdata[PORT_A_BIT], 2))
    else $error("port a mode wrong");
  port_b_a: assert property (host_req_in.wr && host_req_in.addr == IDX_XCVR
    |=> ##1 port_b_line_mode_out == $past(host_req_in.wdata[PORT_B_BIT], 2))
    else $error("port b mode wrong");
  resv_zero_a: assert property (rdata_valid_out |->
    ($past(host_req_in.addr) != IDX_XCVR || rdata_out[7:2] == 6'h00)
    && ($past(host_req_in.addr) != IDX_AUX || rdata_out[3:0] == 4'h0)
    && ($past(host_req_in.addr) != IDX_FAN || rdata_out[7:1] == 7'h00))
    else $error("reserved bit read nonzero");
  tach_upper_a: assert property (rdata_valid_out
    && $past(host_req_in.addr) == IDX_TACHH |-> rdata_out[7:2] == 6'h00)
    else $error("tach upper bits nonzero");
  sleep_fan_a: assert property (sleep_in [*4] |-> !fan_on_out)
    else $error("fan on in sleep");
  fan_off_a: assert property (host_req_in.wr && host_req_in.addr == IDX_FAN
    && host_req_in.wdata[FAN_OFF_BIT] |-> ##[1:2] !fan_on_out)
    else $error("fan not turned off");
  irq_lines_a: assert property (irq_request_out[2:0] == 3'h0
    && !irq_request_out[8] && irq_request_out[15:12] == 4'h0)
    else $error("unmapped interrupt line requested");
endmodule : bmcr_regs_monitor

bind bmcr_regs bmcr_regs_monitor #(.TACH_WINDOW_CYCLES(TACH_WINDOW_CYCLES)) u_monitor (
  .clock_in(clock_in), .reset_in(reset_in), .host_req_in(host_req_in),
  .fan_tach_in(fan_tach_in), .irq_src_in(irq_src_in), .sleep_in(sleep_in),
  .aux_gpio_irq_in(aux_gpio_irq_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out), .port_a_line_mode_out(port_a_line_mode_out),
  .port_b_line_mode_out(port_b_line_mode_out), .fan_on_out(fan_on_out),
  .irq_request_out(irq_request_out));

// ### tb/bmcr_regs_tb_top.sv
// Purpose: Self-checking bench for the board control register bank
// Assumes: Short tach window of WIN cycles
// Notes:   Inputs change 5 ns after the rising edge
module bmcr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bmcr_pkg::*;
  localparam int WIN = 2100;
  logic           clock_in = 1'b0;
  logic           reset_in = 1'b1;
  bmcr_host_req_t req;
  logic           tach = 1'b0;
  bmcr_src_t      src = '0;
  logic           sleep = 1'b0;
  logic           aux = 1'b0;
  logic [7:0]     rdata;
  logic           rvalid, mode_a, mode_b, fan_on;
  logic [15:0]    irq;
  int             n_errors = 0;
  int             checks_done = 0;
  int             tach_per = 0;
  int             tach_cnt = 0;
  int             irq_map [8] = '{3, 4, 5, 10, 6, 7, 9, 11};

  bmcr_regs #(.TACH_WINDOW_CYCLES(WIN)) uut (.clock_in(clock_in), .reset_in(reset_in),
    .host_req_in(req), .fan_tach_in(tach), .irq_src_in(src), .sleep_in(sleep),
    .aux_gpio_irq_in(aux), .rdata_out(rdata), .rdata_valid_out(rvalid),
    .port_a_line_mode_out(mode_a), .port_b_line_mode_out(mode_b),
    .fan_on_out(fan_on), .irq_request_out(irq));
  bmcr_host_model host (.clock_in(clock_in), .rdata_in(rdata),
    .rdata_valid_in(rvalid), .host_req_out(req));

  // Clock and tach pulses, one high cycle per period
  initial forever #50 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    #5 tach = (tach_per != 0) && (tach_cnt == 0);
    tach_cnt = (tach_per == 0) ? 0 : (tach_cnt + 1) % tach_per;
  end

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk($sformatf("reg %0d", a), 16'(e), 16'(d));
  endtask : rchk
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #5;
  endtask : step
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #5 reset_in = 1'b0;
  endtask : do_reset

  task automatic t_reset();
    for (int i = 0; i < 7; i++) rchk(3'(i), 8'h00);
    rchk(3'h7, 8'h00);
    chk("modes", 16'h0, 16'({mode_b, mode_a}));
    chk("irq", 16'h0000, irq);
    chk("fan", 16'h1, 16'(fan_on));
    $display("done: reset");
  endtask : t_reset
  task automatic t_xcvr();
    host.wr_reg(IDX_XCVR, 8'hff);
    rchk(IDX_XCVR, 8'h03);
    chk("modes", 16'h3, 16'({mode_b, mode_a}));
    host.wr_reg(IDX_XCVR, 8'h02);
    step(2);
    chk("modes", 16'h2, 16'({mode_b, mode_a}));
    $display("done: xcvr");
  endtask : t_xcvr
  task automatic t_aux();
    host.wr_reg(IDX_AUX, 8'hff);
    rchk(IDX_AUX, 8'hf0);
    aux = 1'b1;
    for (int s = 0; s < 8; s++) begin
      host.wr_reg(IDX_AUX, {1'b1, 3'(s), 4'h0});
      step(2);
      chk("aux irq", 16'h1 << irq_map[s], irq);
    end
    host.wr_reg(IDX_AUX, 8'h70);
    step(2);
    chk("aux irq", 16'h0000, irq);
    aux = 1'b0;
    $display("done: aux");
  endtask : t_aux
  task automatic t_fan();
    host.wr_reg(IDX_FAN, 8'hff);
    rchk(IDX_FAN, 8'h01);
    chk("fan", 16'h0, 16'(fan_on));
    host.wr_reg(IDX_FAN, 8'h00);
    step(2);
    chk("fan", 16'h1, 16'(fan_on));
    sleep = 1'b1;
    step(4);
    chk("fan", 16'h0, 16'(fan_on));
    sleep = 1'b0;
    host.wr_reg(IDX_FAN, 8'h01);
    do_reset();
    step(4);
    chk("fan", 16'h1, 16'(fan_on));
    rchk(IDX_FAN, 8'h00);
    host.wr_reg(IDX_FAN, 8'h01);
    step(2);
    chk("fan", 16'h0, 16'(fan_on));
    $display("done: fan");
  endtask : t_fan
  task automatic t_therm();
    host.wr_reg(IDX_TICR, 8'hff);
    rchk(IDX_TICR, 8'hff);
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(IDX_TICR, {1'b1, 3'(i), 4'h1 << i});
      src[i] = 1'b1;
      step(5);
      src[i] = 1'b0;
      step(3);
      rchk(IDX_TSTAT, 8'h01 << i);
      chk("thermal irq", 16'h1 << irq_map[i], irq);
      host.wr_reg(IDX_TICR, {1'b1, 3'(i), ~(4'h1 << i)});
      step(2);
      chk("thermal irq", 16'h0000, irq);
      host.wr_reg(IDX_TSTAT, 8'h01 << i);
      rchk(IDX_TSTAT, 8'h00);
    end
    $display("done: thermal");
  endtask : t_therm
  task automatic t_tach();
    tach_per = 4;
    step(2 * WIN + 10);
    rchk(IDX_TACHL, 8'h0d);
    tach_per = 2;
    step(2 * WIN + 10);
    rchk(IDX_TACHH, 8'h02);
    rchk(IDX_TACHL, 8'hff);
    rchk(IDX_TACHH, 8'h03);
    tach_per = 0;
    $display("done: tach");
  endtask : t_tach

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    do_reset();
    t_reset();
    t_xcvr();
    t_aux();
    t_fan();
    t_therm();
    t_tach();
    end_of_test();
  end
  // Watchdog
  initial begin
    #2000000 n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : bmcr_regs_tb_top
